// *** link_config_defines.vh ***
// offsets, field positions, write mask and timing figures of the link config
`ifndef LINK_CONFIG_DEFINES_VH
`define LINK_CONFIG_DEFINES_VH

// ==========================================================================
// register byte addresses
`define LOC_OFF          8'h00
`define CTRL_OFF         8'h04
`define STAT_OFF         8'h08

// ==========================================================================
// link_output_config fields
`define RATE_LSB         0
`define RATE_MSB         7
`define HOST_SPD_LSB     8
`define HOST_SPD_MSB     10
`define RX_SPD_LSB       11
`define RX_SPD_MSB       13
`define RSV_LO_BIT       14
`define FIRST_TYPE_BIT   15
`define LAST_TYPE_BIT    29
`define AUTO_SEND_BIT    30
`define RSV_HI_BIT       31
`define LOC_WR_MASK      32'h7FFFBFFF
`define NUM_TYPES        15
`define QUAT_TYPE        4'h8

// ==========================================================================
// control fields (write one to act)
`define CTRL_COMMIT_BIT  0
`define CTRL_POLL_BIT    1

// ==========================================================================
// rate law: freq = (280/255)*code + 20 Hz
`define RATE_NUM         280
`define RATE_DEN         255
`define RATE_BASE_HZ     20
`define CLK_HZ_DEFAULT   20000000

// ==========================================================================
// serial speeds in baud
`define BAUD_9600        18'd9600
`define BAUD_14400       18'd14400
`define BAUD_19200       18'd19200
`define BAUD_38400       18'd38400
`define BAUD_57600       18'd57600
`define BAUD_115200      18'd115200
`define SPD_115200_CODE  3'h5

`endif

// *** link_output_config.v ***
// communication configuration register with broadcast and baud schedulers
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "link_config_defines.vh"

module link_output_config #(
    parameter CLK_HZ = `CLK_HZ_DEFAULT,
    parameter AW     = 8
) (
    input  wire          i_ref_clk,
    input  wire          i_rst_b,
    input  wire          i_psel,
    input  wire          i_penable,
    input  wire          i_pwrite,
    input  wire [AW-1:0] i_paddr,
    input  wire [31:0]   i_pwdata,
    output reg  [31:0]   o_prdata,
    output wire          o_pready,
    output wire          o_pslverr,
    input  wire [31:0]   i_stored_config,
    input  wire          i_quat_estimation_on,
    input  wire          i_pkt_ready,
    output reg           o_pkt_valid,
    output reg  [3:0]    o_pkt_type,
    output reg           o_pkt_data_valid,
    output reg           o_commit_strobe,
    output reg  [31:0]   o_commit_word,
    output reg  [2:0]    o_host_speed_code,
    output reg  [2:0]    o_receiver_speed_code,
    output reg           o_host_baud_tick,
    output reg           o_receiver_baud_tick,
    output reg           o_rate_tick
);

    // ======================================================================
    // constants
    localparam [2:0]  ST_LOAD  = 3'b001;
    localparam [2:0]  ST_IDLE  = 3'b010;
    localparam [2:0]  ST_SEND  = 3'b100;
    localparam [33:0] RATE_THR = 34'd255 * CLK_HZ;
    localparam [31:0] CLK_W    = CLK_HZ;
    localparam [31:0] RATE_K_W = `RATE_NUM;
    localparam [31:0] RATE_B_W = `RATE_BASE_HZ * `RATE_DEN;
    localparam [25:0] BAUD_THR = CLK_W[25:0];
    localparam [16:0] RATE_K   = RATE_K_W[16:0];
    localparam [16:0] RATE_B   = RATE_B_W[16:0];

    // ======================================================================
    // functions
    // baud for a speed code, zero when the code is not valid
    function [17:0] baud_of;
        input [2:0] code;
        input       allow_fast;
        begin
            case (code)
                3'h0: baud_of = `BAUD_9600;
                3'h1: baud_of = `BAUD_14400;
                3'h2: baud_of = `BAUD_19200;
                3'h3: baud_of = `BAUD_38400;
                3'h4: baud_of = `BAUD_57600;
                3'h5: baud_of = allow_fast ? `BAUD_115200 : 18'h00000;
                default: baud_of = 18'h00000;
            endcase
        end
    endfunction

    // lowest set bit wins, giving the fixed send order
    function [3:0] first_set;
        input [`NUM_TYPES-1:0] mask;
        integer k;
        begin
            first_set = 4'h0;
            for (k = `NUM_TYPES - 1; k >= 0; k = k - 1) begin
                if (mask[k])
                    first_set = k[3:0];
            end
        end
    endfunction

    // ======================================================================
    // registers
    reg [31:0]            loc_cfg;
    reg [2:0]             state;
    reg [`NUM_TYPES-1:0]  pending;
    reg                   tick_pending;
    reg                   poll_pending;
    reg [33:0]            rate_acc;
    reg [25:0]            host_acc;
    reg [25:0]            rx_acc;
    reg [17:0]            host_baud;
    reg [17:0]            rx_baud;

    wire                  wr_en;
    wire                  rd_en;
    wire                  addr_ok;
    wire                  ctrl_wr;
    wire [7:0]            rate_code;
    wire [2:0]            host_code;
    wire [2:0]            rx_code;
    wire [`NUM_TYPES-1:0] type_en;
    wire                  auto_send;
    wire [17:0]           host_req;
    wire [17:0]           rx_req;
    wire [16:0]           rate_inc;
    wire [33:0]           rate_sum;
    wire [25:0]           host_sum;
    wire [25:0]           rx_sum;
    wire [`NUM_TYPES-1:0] next_pending;
    wire [3:0]            next_type;

    // ======================================================================
    // apb slave, zero wait states
    assign o_pready  = 1'b1;
    assign addr_ok   = (i_paddr == `LOC_OFF) || (i_paddr == `CTRL_OFF) ||
                       (i_paddr == `STAT_OFF);
    assign o_pslverr = i_psel & i_penable & ~addr_ok;
    assign wr_en     = i_psel & i_penable & i_pwrite & addr_ok;
    assign rd_en     = i_psel & ~i_penable & ~i_pwrite;
    assign ctrl_wr   = wr_en && (i_paddr == `CTRL_OFF);

    // read data prepared in setup so it is a flop during access
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (i_paddr)
                `LOC_OFF:  o_prdata <= loc_cfg & `LOC_WR_MASK;
                `STAT_OFF: o_prdata <= {19'h00000, o_pkt_type,
                                        ~state[0], state[2],
                                        rx_code == o_receiver_speed_code,
                                        o_receiver_speed_code,
                                        o_host_speed_code};
                default:   o_prdata <= 32'h00000000;
            endcase
        end
    end

    // ======================================================================
    // configuration word
    // no documented reset value: first clock after release loads the
    // stored image, so a speed never committed is lost at power-up
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            loc_cfg <= 32'h00000000;
        end else if (state == ST_LOAD) begin
            loc_cfg <= i_stored_config & `LOC_WR_MASK;
        end else if (wr_en && (i_paddr == `LOC_OFF)) begin
            loc_cfg <= i_pwdata & `LOC_WR_MASK;
        end
    end

    assign rate_code = loc_cfg[`RATE_MSB:`RATE_LSB];
    assign host_code = loc_cfg[`HOST_SPD_MSB:`HOST_SPD_LSB];
    assign rx_code   = loc_cfg[`RX_SPD_MSB:`RX_SPD_LSB];
    assign type_en   = loc_cfg[`LAST_TYPE_BIT:`FIRST_TYPE_BIT];
    assign auto_send = loc_cfg[`AUTO_SEND_BIT];

    // commit hands the live word to the store; the host must already talk
    // at the speed it selected, otherwise this command never arrives
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_commit_strobe <= 1'b0;
            o_commit_word   <= 32'h00000000;
        end else begin
            o_commit_strobe <= ctrl_wr & i_pwdata[`CTRL_COMMIT_BIT];
            if (ctrl_wr && i_pwdata[`CTRL_COMMIT_BIT])
                o_commit_word <= loc_cfg;
        end
    end

    // ======================================================================
    // serial speed dividers
    // invalid codes keep the last valid speed rather than stop the link
    assign host_req = baud_of(host_code, 1'b0);
    assign rx_req   = baud_of(rx_code, 1'b1);

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            host_baud             <= `BAUD_9600;
            rx_baud               <= `BAUD_9600;
            o_host_speed_code     <= 3'h0;
            o_receiver_speed_code <= 3'h0;
        end else begin
            if (host_req != 18'h00000) begin
                host_baud         <= host_req;
                o_host_speed_code <= host_code;
            end
            if (rx_req != 18'h00000) begin
                rx_baud               <= rx_req;
                o_receiver_speed_code <= rx_code;
            end
        end
    end

    // fractional accumulators keep the mean rate exact
    assign host_sum = host_acc + {8'h00, host_baud};
    assign rx_sum   = rx_acc + {8'h00, rx_baud};

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            host_acc             <= 26'h0000000;
            rx_acc               <= 26'h0000000;
            o_host_baud_tick     <= 1'b0;
            o_receiver_baud_tick <= 1'b0;
        end else begin
            o_host_baud_tick     <= (host_sum >= BAUD_THR);
            o_receiver_baud_tick <= (rx_sum >= BAUD_THR);
            if (host_sum >= BAUD_THR)
                host_acc <= host_sum - BAUD_THR;
            else
                host_acc <= host_sum;
            if (rx_sum >= BAUD_THR)
                rx_acc <= rx_sum - BAUD_THR;
            else
                rx_acc <= rx_sum;
        end
    end

    // ======================================================================
    // broadcast period
    // adding 280*code+5100 per cycle against clk*255 gives exactly
    // (280/255)*code+20 ticks per second
    assign rate_inc = RATE_K * {9'h000, rate_code} + RATE_B;
    assign rate_sum = rate_acc + {17'h00000, rate_inc};

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rate_acc    <= 34'h000000000;
            o_rate_tick <= 1'b0;
        end else if (!auto_send) begin
            rate_acc    <= 34'h000000000;
            o_rate_tick <= 1'b0;
        end else begin
            o_rate_tick <= (rate_sum >= RATE_THR);
            if (rate_sum >= RATE_THR)
                rate_acc <= rate_sum - RATE_THR;
            else
                rate_acc <= rate_sum;
        end
    end

    // ======================================================================
    // packet scheduler
    // one tick may wait behind a running burst; further ones merge
    assign next_pending = pending & ~({{(`NUM_TYPES-1){1'b0}}, 1'b1}
                                      << o_pkt_type);
    assign next_type    = first_set(next_pending);

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state            <= ST_LOAD;
            pending          <= {`NUM_TYPES{1'b0}};
            tick_pending     <= 1'b0;
            poll_pending     <= 1'b0;
            o_pkt_valid      <= 1'b0;
            o_pkt_type       <= 4'h0;
            o_pkt_data_valid <= 1'b0;
        end else begin
            // set wins over the clear taken when a burst starts
            if (o_rate_tick)
                tick_pending <= 1'b1;
            else if (state == ST_IDLE)
                tick_pending <= 1'b0;
            if (ctrl_wr && i_pwdata[`CTRL_POLL_BIT])
                poll_pending <= 1'b1;
            else if (state == ST_IDLE)
                poll_pending <= 1'b0;
            case (state)
                ST_LOAD: begin
                    state <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (((tick_pending && auto_send) || poll_pending) &&
                        (type_en != {`NUM_TYPES{1'b0}})) begin
                        // enables sampled once per burst
                        pending     <= type_en;
                        o_pkt_type  <= first_set(type_en);
                        o_pkt_valid <= 1'b1;
                        o_pkt_data_valid <= ~((first_set(type_en) ==
                            `QUAT_TYPE) & ~i_quat_estimation_on);
                        state       <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (i_pkt_ready) begin
                        pending <= next_pending;
                        if (next_pending == {`NUM_TYPES{1'b0}}) begin
                            o_pkt_valid <= 1'b0;
                            state       <= ST_IDLE;
                        end else begin
                            o_pkt_type  <= next_type;
                            o_pkt_data_valid <= ~((next_type ==
                                `QUAT_TYPE) & ~i_quat_estimation_on);
                        end
                    end
                end
                default: begin
                    state       <= ST_IDLE;
                    o_pkt_valid <= 1'b0;
                end
            endcase
        end
    end

    // types 9..14 are processed mag, accel, gyro and raw mag, accel, gyro

endmodule

// *** link_output_config_asserts.sv ***
// concurrent checks on the link config ports
`timescale 1ns/10ps
`include "link_config_defines.vh"
module link_cfg_checker #(
    parameter AW = 8
) (
    input wire          i_ref_clk,
    input wire          i_rst_b,
    input wire          i_psel,
    input wire          i_penable,
    input wire          i_pwrite,
    input wire [AW-1:0] i_paddr,
    input wire [31:0]   i_pwdata,
    input wire [31:0]   o_prdata,
    input wire          o_pready,
    input wire          o_pslverr,
    input wire          i_quat_estimation_on,
    input wire          i_pkt_ready,
    input wire          o_pkt_valid,
    input wire [3:0]    o_pkt_type,
    input wire          o_pkt_data_valid,
    input wire          o_commit_strobe,
    input wire          o_rate_tick
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    wire acc = i_psel & i_penable;
    wire hit = i_paddr == `LOC_OFF || i_paddr == `CTRL_OFF
               || i_paddr == `STAT_OFF;
    // ==================================================================
    // sequences
    sequence commit_req;
        acc && i_pwrite && i_paddr == `CTRL_OFF && i_pwdata[0];
    endsequence
    sequence pkt_sent;
        o_pkt_valid && i_pkt_ready;
    endsequence
    // ==================================================================
    // assertions
    chk_commit_pulse: assert property (commit_req |=> o_commit_strobe ##1 !o_commit_strobe)
        else $error("commit strobe not a single pulse after command");
    chk_commit_cause: assert property (o_commit_strobe |-> $past(acc && i_pwrite && i_paddr == `CTRL_OFF && i_pwdata[0]))
        else $error("commit strobe without command");
    chk_ready_high: assert property (acc |-> o_pready)
        else $error("access phase without ready");
    chk_slverr_map: assert property (acc |-> o_pslverr == !hit)
        else $error("slave error does not match address map");
    chk_ctrl_zero: assert property (acc && !i_pwrite && i_paddr == `CTRL_OFF |-> o_prdata == 32'h0)
        else $error("control register read not zero");
    chk_pkt_hold: assert property (o_pkt_valid && !i_pkt_ready |=> o_pkt_valid && $stable(o_pkt_type))
        else $error("packet request dropped before acceptance");
    chk_type_range: assert property (o_pkt_valid |-> o_pkt_type <= 4'hE)
        else $error("packet type out of range");
    chk_quat_valid: assert property (o_pkt_valid |-> o_pkt_data_valid == !(o_pkt_type == `QUAT_TYPE && !i_quat_estimation_on))
        else $error("quaternion data valid flag wrong");
    chk_type_order: assert property (pkt_sent ##1 o_pkt_valid |-> o_pkt_type > $past(o_pkt_type))
        else $error("packet types not in rising order");
    chk_rate_pulse: assert property (o_rate_tick |=> !o_rate_tick)
        else $error("rate tick longer than one cycle");
endmodule

bind link_output_config link_cfg_checker #(.AW(AW)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_quat_estimation_on(i_quat_estimation_on),
    .i_pkt_ready(i_pkt_ready), .o_pkt_valid(o_pkt_valid),
    .o_pkt_type(o_pkt_type), .o_pkt_data_valid(o_pkt_data_valid),
    .o_commit_strobe(o_commit_strobe), .o_rate_tick(o_rate_tick)
);

// *** pkt_sink.sv ***
// packet sender model, accepting at once or one cycle in four
`timescale 1ns/10ps
module pkt_sink (
    input  wire i_ref_clk,
    input  wire i_rst_b,
    input  wire i_slow,
    output reg  o_pkt_ready
);
    reg [1:0] cnt;
    // slow mode stalls three of four cycles, like a busy uart
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 2'h0;
            o_pkt_ready <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            o_pkt_ready <= !i_slow || cnt == 2'h3;
        end
    end
endmodule

// *** tb_link_output_config.sv ***
// self-checking bench of the link config register
`timescale 1ns/10ps
`include "link_config_defines.vh"
module tb_link_output_config;
    localparam CLK = 200000;
    reg         clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, stored = 32'h80004201, rd;
    reg         er, quat = 0, slow = 0;
    wire [31:0] prdata, cword;
    wire        pready, pslverr, prdy, pval, dval, cstb, htk, rtk, rate;
    wire [3:0]  ptype;
    wire [2:0]  hcode, rcode;
    integer     failures = 0, checked = 0, i, n, t0;
    reg  [4:0]  q[$];
    reg  [31:0] row[0:7][0:3];
    always #25 clk = ~clk;
    link_output_config #(.CLK_HZ(CLK)) u_dut (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_stored_config(stored), .i_quat_estimation_on(quat),
        .i_pkt_ready(prdy), .o_pkt_valid(pval), .o_pkt_type(ptype),
        .o_pkt_data_valid(dval), .o_commit_strobe(cstb),
        .o_commit_word(cword), .o_host_speed_code(hcode),
        .o_receiver_speed_code(rcode), .o_host_baud_tick(htk),
        .o_receiver_baud_tick(rtk), .o_rate_tick(rate));
    pkt_sink u_sink (.i_ref_clk(clk), .i_rst_b(rst_b), .i_slow(slow),
        .o_pkt_ready(prdy));
    always @(posedge clk) if (pval && prdy) q.push_back({dval, ptype});
    // ==================================================================
    // tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task near(input string nm, input integer e, input integer g);
        checked++;
        if (g < e - 2 || g > e + 2) begin
            failures++;
            $display("[ERR] %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    function integer baud(input logic [2:0] c);
        baud = c == 0 ? 9600 : c == 1 ? 14400 : c == 2 ? 19200 :
               c == 3 ? 38400 : c == 4 ? 57600 : 115200;
    endfunction
    task tally_and_finish;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task burst(input logic [31:0] cfg, input integer cnt);
        q.delete();
        apb(1, `LOC_OFF, cfg);
        apb(1, `CTRL_OFF, 32'h2);
        for (n = 0; n < 400 && q.size() < cnt; n++) @(posedge clk);
        chk("burst count", cnt, q.size());
    endtask
    // ==================================================================
    // sequence
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        tally_and_finish;
    end
    initial begin
        // write data, read back, host code, receiver code
        row = '{'{32'h0, 32'h0, 0, 0}, '{32'h2C00, 32'h2C00, 4, 5},
            '{32'h3F00, 32'h3F00, 4, 5}, '{32'h80007300, 32'h3300, 3, 5},
            '{32'h0900, 32'h0900, 1, 1}, '{32'h1200, 32'h1200, 2, 2},
            '{32'h1800, 32'h1800, 0, 3}, '{32'h2000, 32'h2000, 0, 4}};
        repeat (10) @(posedge clk);
        rst_b <= 1;
        repeat (2) @(posedge clk);
        apb(0, `LOC_OFF, 32'h0);
        chk("stored image", 32'h00000201, rd);
        chk("host code", 3'h2, hcode);
        apb(0, `STAT_OFF, 32'h0);
        chk("status", 32'h00000142, rd);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            apb(1, `LOC_OFF, row[i][0]);
            apb(0, `LOC_OFF, 32'h0);
            chk("readback", row[i][1], rd);
            chk("host code", row[i][2], hcode);
            chk("rx code", row[i][3], rcode);
            n = 0;
            t0 = 0;
            repeat (500) begin
                @(posedge clk);
                n += htk;
                t0 += rtk;
            end
            near("host ticks", 500 * baud(row[i][2]) / CLK, n);
            near("rx ticks", 500 * baud(row[i][3]) / CLK, t0);
        end
        $display("test speeds done");
        apb(1, 8'h0C, 32'hFFFFFFFF);
        chk("unmapped err", 1, er);
        apb(0, 8'h0C, 32'h0);
        chk("unmapped data", 0, rd);
        apb(0, `CTRL_OFF, 32'h0);
        chk("ctrl read", 0, rd);
        apb(0, `LOC_OFF, 32'h0);
        chk("after unmapped", 32'h2000, rd);
        apb(1, `LOC_OFF, 32'h00001234);
        apb(1, `CTRL_OFF, 32'h1);
        for (n = 0; n < 4 && cstb !== 1'b1; n++) @(posedge clk);
        chk("commit strobe", 1, cstb);
        chk("commit word", 32'h00001234, cword);
        $display("test map and commit done");
        quat <= 1;
        slow <= 1;
        burst(32'h3FFF8000, 15);
        for (i = 0; i < 15 && i < q.size(); i++)
            chk("burst type", {1'b1, i[3:0]}, q[i]);
        quat <= 0;
        slow <= 0;
        burst(32'h20808000, 3);
        chk("type 0", 5'h10, q[0]);
        chk("quat invalid", 5'h08, q[1]);
        chk("raw gyro", 5'h1E, q[2]);
        $display("test bursts done");
        repeat (1500) @(posedge clk);
        chk("no auto ticks", 0, rate);
        apb(1, `LOC_OFF, 32'h400000FF);
        for (n = 0; n < 1000 && rate !== 1'b1; n++) @(posedge clk);
        t0 = 0;
        for (n = 0; n < 1000 && (t0 == 0 || rate !== 1'b1); n++) begin
            @(posedge clk);
            t0++;
        end
        near("period 255", CLK * 255 / 76500, t0);
        apb(1, `LOC_OFF, 32'h40000000);
        for (n = 0; n < 12000 && rate !== 1'b1; n++) @(posedge clk);
        t0 = 0;
        for (n = 0; n < 12000 && (t0 == 0 || rate !== 1'b1); n++) begin
            @(posedge clk);
            t0++;
        end
        near("period 0", CLK / 20, t0);
        $display("test rate done");
        tally_and_finish;
    end
endmodule
